// ---- atsr_pkg.sv ----
package atsr_pkg;

	// ****************************************
	// clock and line timing
	// ****************************************
	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned BAUD_BPS    = 9600;
	localparam int unsigned GAP_MS      = 400;
	// bit time rounds down; 0.02 % fast, well inside any receiver margin
	localparam int unsigned BIT_CYCLES  = CLK_HZ / BAUD_BPS;
	localparam int unsigned GAP_CYCLES  = (CLK_HZ / 1000) * GAP_MS;
	localparam int unsigned TIMER_W     = 24;

	// ****************************************
	// character framing
	// ****************************************
	localparam int unsigned CHAR_W      = 7;
	localparam int unsigned FRAME_BITS  = 10;
	localparam int unsigned REPORT_LEN  = 8;
	localparam int unsigned ALARM_LEN   = 7;
	localparam int unsigned DIGITS      = 5;
	localparam int unsigned FIFO_DEPTH  = 4;

	// ****************************************
	// turn count
	// ****************************************
	localparam int unsigned COUNT_W          = 16;
	localparam logic [15:0] TURN_LIMIT_DEFAULT = 16'hFFFF;
	localparam logic [15:0] COUNT_ZERO       = 16'h0000;
	localparam logic [15:0] COUNT_ONE        = 16'h0001;

	// ****************************************
	// ascii codes
	// ****************************************
	localparam logic [6:0] ASC_P     = 7'h50;
	localparam logic [6:0] ASC_PLUS  = 7'h2B;
	localparam logic [6:0] ASC_MINUS = 7'h2D;
	localparam logic [6:0] ASC_ZERO  = 7'h30;
	localparam logic [6:0] ASC_A     = 7'h41;
	localparam logic [6:0] ASC_L     = 7'h4C;
	localparam logic [6:0] ASC_M     = 7'h4D;
	localparam logic [6:0] ASC_DOT   = 7'h2E;
	localparam logic [6:0] ASC_CR    = 7'h0D;
	localparam logic [6:0] HEX_TEN   = 7'h0A;

	// revolution step pulses from the encoder front end
	typedef struct packed {
		logic fwd;
		logic rev;
	} atsr_step_s;

	typedef enum logic [1:0] {
		PR_IDLE,
		PR_CONV,
		PR_EMIT
	} atsr_prod_e;

	typedef enum logic {
		TX_IDLE,
		TX_SHIFT
	} atsr_tx_e;

endpackage : atsr_pkg

// ---- atsr_fifo.sv ----
`timescale 1ns/10ps

module atsr_fifo
	import atsr_pkg::*;
#(
	parameter int unsigned WIDTH = CHAR_W,
	parameter int unsigned DEPTH = FIFO_DEPTH
)(
	input  wire logic             sys_clk,   // system clock
	input  wire logic             rst,       // sync reset, high
	input  wire logic             in_valid,  // writer offers a word
	output logic                  in_ready,  // room for a word
	input  wire logic [WIDTH-1:0] in_data,   // word written
	output logic                  out_valid, // a word is waiting
	input  wire logic             out_ready, // reader takes the word
	output logic      [WIDTH-1:0] out_data   // oldest word, from storage
);

	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PTR_W:0] DEPTH_L = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W-1:0] LAST_L = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0]   fill_reg;
	logic             push;
	logic             pop;

	// full and empty follow the fill count directly
	assign in_ready  = (fill_reg != DEPTH_L);
	assign out_valid = (fill_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];

	// storage is written only, never reset
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// pointers and fill count
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			fill_reg   <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == LAST_L) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == LAST_L) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop)
				fill_reg <= fill_reg + 1'b1;
			else if (pop && !push)
				fill_reg <= fill_reg - 1'b1;
		end
	end

endmodule : atsr_fifo

// ---- atsr_reporter.sv ----
`timescale 1ns/10ps

// Function
// - turns sent as async frames on serial out
// - eight chars: P, sign, five digits, CR
// - zero count reports as five zero digits
// - default limit wraps signed 16-bit count
// - with absolute encoder, sensor command on-to-off sends alarm text
// - sensor command ignored while motor powered
// - with absolute encoder, reverse at zero loads the turn limit
// - with absolute encoder, forward at the limit clears to zero
// - limit 0..65535, default 65535, read at restart
// - pulse mode resumes 400 ms after report
module atsr_reporter
	import atsr_pkg::*;
#(
	parameter int unsigned BIT_CYC = BIT_CYCLES,
	parameter int unsigned GAP_CYC = GAP_CYCLES
)(
	input  wire logic               sys_clk,             // system clock, 40 MHz
	input  wire logic               rst,                 // sync reset, high
	input  wire atsr_step_s         rev_step,            // one-cycle revolution pulses
	input  wire logic               abs_encoder_fitted,  // absolute encoder present
	input  wire logic               motor_power_on,      // motor energised
	input  wire logic               sensor_activate_cmd, // host command level
	input  wire logic [15:0]        turn_wrap_limit,     // limit setting, read at restart
	input  wire logic [7:0]         alarm_code,          // two hex digits of alarm
	output logic                    turns_serial_out,    // serial line to host
	output logic                    pulse_mode_active,   // line handed to pulse output
	output logic [COUNT_W-1:0]      turn_count,          // current revolution count
	output logic                    report_busy          // report or alarm in flight
);

	// ****************************************
	// declarations
	// ****************************************
	logic [15:0]        limit_reg;
	logic               limit_loaded_reg;
	logic [COUNT_W-1:0] count_reg;
	logic               cmd_prev_reg;
	atsr_prod_e         prod_reg;
	logic               alarm_mode_reg;
	logic               report_sent_reg;
	logic [2:0]         char_idx_reg;
	logic [2:0]         dig_idx_reg;
	logic [16:0]        rem_reg;
	logic [3:0]         digit_reg [DIGITS];
	logic               sign_neg_reg;
	logic [7:0]         alarm_reg;
	atsr_tx_e           tx_reg;
	logic [FRAME_BITS-1:0] shift_reg;
	logic [3:0]         bit_cnt_reg;
	logic [TIMER_W-1:0] baud_cnt_reg;
	logic [TIMER_W-1:0] gap_cnt_reg;
	logic               gap_run_reg;
	logic               line_reg;
	logic               pulse_mode_reg;

	logic               custom_limit;
	logic               cmd_rise;
	logic               cmd_fall;
	logic               fifo_in_ready;
	logic               fifo_out_valid;
	logic               fifo_out_ready;
	logic [CHAR_W-1:0]  fifo_out_data;
	logic               emit_valid;
	logic [CHAR_W-1:0]  emit_char;
	logic               emit_last;
	logic [16:0]        weight;

	localparam logic [3:0]         LAST_BIT  = 4'(FRAME_BITS - 1);
	localparam logic [2:0]         LAST_DIG  = 3'(DIGITS - 1);
	localparam logic [2:0]         REP_LAST  = 3'(REPORT_LEN - 1);
	localparam logic [2:0]         ALM_LAST  = 3'(ALARM_LEN - 1);
	localparam logic [TIMER_W-1:0] BIT_LAST  = TIMER_W'(BIT_CYC - 1);
	localparam logic [TIMER_W-1:0] GAP_LAST  = TIMER_W'(GAP_CYC - 1);

	// ****************************************
	// helper functions
	// ****************************************
	function automatic logic [6:0] hex_ascii(input logic [3:0] nib);
		logic [6:0] n;
		n = {3'h0, nib};
		hex_ascii = (n < HEX_TEN) ? ASC_ZERO + n : ASC_A + (n - HEX_TEN);
	endfunction : hex_ascii

	// decimal weight of digit position, most significant first
	function automatic logic [16:0] dec_weight(input logic [2:0] idx);
		unique case (idx)
			3'h0:    dec_weight = 17'h02710;
			3'h1:    dec_weight = 17'h003E8;
			3'h2:    dec_weight = 17'h00064;
			3'h3:    dec_weight = 17'h0000A;
			default: dec_weight = 17'h00001;
		endcase
	endfunction : dec_weight

	// ****************************************
	// turn count and limit
	// ****************************************
	// limit captured once after restart
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			limit_reg        <= TURN_LIMIT_DEFAULT;
			limit_loaded_reg <= 1'b0;
		end
		else if (!limit_loaded_reg)
		begin
			limit_reg        <= turn_wrap_limit;
			limit_loaded_reg <= 1'b1;
		end
	end

	// custom limit only with an absolute encoder
	assign custom_limit = abs_encoder_fitted && (limit_reg != TURN_LIMIT_DEFAULT);

	// simultaneous fwd and rev pulses cancel out
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			count_reg <= COUNT_ZERO;
		else if (rev_step.fwd && !rev_step.rev)
		begin
			if (custom_limit && count_reg == limit_reg)
				count_reg <= COUNT_ZERO;
			// default wraps +32767 to -32768 naturally
			else
				count_reg <= count_reg + COUNT_ONE;
		end
		else if (rev_step.rev && !rev_step.fwd)
		begin
			if (custom_limit && count_reg == COUNT_ZERO)
				count_reg <= limit_reg;
			else
				count_reg <= count_reg - COUNT_ONE;
		end
	end

	assign turn_count = count_reg;

	// ****************************************
	// sensor command edges
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			cmd_prev_reg <= 1'b0;
		else
			cmd_prev_reg <= sensor_activate_cmd;
	end

	// edges taken only with motor power off
	assign cmd_rise = sensor_activate_cmd && !cmd_prev_reg && !motor_power_on;
	assign cmd_fall = !sensor_activate_cmd && cmd_prev_reg && !motor_power_on;

	// ****************************************
	// character producer
	// ****************************************
	assign weight = dec_weight(dig_idx_reg);

	// producer sequence; new commands are dropped until the producer is back in PR_IDLE
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			prod_reg       <= PR_IDLE;
			alarm_mode_reg <= 1'b0;
			char_idx_reg   <= '0;
			dig_idx_reg    <= '0;
			rem_reg        <= '0;
			sign_neg_reg   <= 1'b0;
			alarm_reg      <= '0;
		end
		else
		begin
			unique case (prod_reg)
				PR_IDLE:
				begin
					char_idx_reg <= '0;
					dig_idx_reg  <= '0;
					if (cmd_rise)
					begin
						alarm_mode_reg <= 1'b0;
						// signed view only under the default limit
						sign_neg_reg   <= !custom_limit && count_reg[COUNT_W-1];
						if (!custom_limit && count_reg[COUNT_W-1])
							rem_reg <= 17'(-$signed({count_reg[COUNT_W-1], count_reg}));
						else
							rem_reg <= {1'b0, count_reg};
						prod_reg <= PR_CONV;
					end
					else if (cmd_fall && abs_encoder_fitted)
					begin
						alarm_mode_reg <= 1'b1;
						alarm_reg      <= alarm_code;
						prod_reg       <= PR_EMIT;
					end
				end
				PR_CONV:
				begin
					// repeated subtraction, at most nine steps a digit
					if (rem_reg >= weight)
						rem_reg <= rem_reg - weight;
					else if (dig_idx_reg == LAST_DIG)
						prod_reg <= PR_EMIT;
					else
						dig_idx_reg <= dig_idx_reg + 3'h1;
				end
				PR_EMIT:
				begin
					if (emit_valid && fifo_in_ready)
					begin
						char_idx_reg <= char_idx_reg + 3'h1;
						if (emit_last)
							prod_reg <= PR_IDLE;
					end
				end
				default: prod_reg <= PR_IDLE;
			endcase
		end
	end

	// digits start at zero, so a zero count gives 00000
	always_ff @(posedge sys_clk)
	begin
		if (rst || (prod_reg == PR_IDLE))
		begin
			for (int i = 0; i < DIGITS; i++)
				digit_reg[i] <= 4'h0;
		end
		else if (prod_reg == PR_CONV && rem_reg >= weight)
			digit_reg[dig_idx_reg] <= digit_reg[dig_idx_reg] + 4'h1;
	end

	// report layout, alarm layout beside it
	always_comb
	begin
		emit_valid = (prod_reg == PR_EMIT);
		emit_char  = ASC_CR;
		if (alarm_mode_reg)
		begin
			emit_last = (char_idx_reg == ALM_LAST);
			unique case (char_idx_reg)
				3'h0:    emit_char = ASC_A;
				3'h1:    emit_char = ASC_L;
				3'h2:    emit_char = ASC_M;
				3'h3:    emit_char = hex_ascii(alarm_reg[7:4]);
				3'h4:    emit_char = hex_ascii(alarm_reg[3:0]);
				3'h5:    emit_char = ASC_DOT;
				default: emit_char = ASC_CR;
			endcase
		end
		else
		begin
			emit_last = (char_idx_reg == REP_LAST);
			unique case (char_idx_reg)
				3'h0:    emit_char = ASC_P;
				3'h1:    emit_char = sign_neg_reg ? ASC_MINUS : ASC_PLUS;
				3'h7:    emit_char = ASC_CR;
				default: emit_char = ASC_ZERO + {3'h0, digit_reg[char_idx_reg - 3'h2]};
			endcase
		end
	end

	// ****************************************
	// character buffer
	// ****************************************
	atsr_fifo #(
		.WIDTH (CHAR_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_valid  (emit_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (emit_char),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	// ****************************************
	// serial transmitter
	// ****************************************
	assign fifo_out_ready = (tx_reg == TX_IDLE);

	// start-stop framing on the shared line
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tx_reg       <= TX_IDLE;
			shift_reg    <= '1;
			bit_cnt_reg  <= '0;
			baud_cnt_reg <= '0;
			line_reg     <= 1'b1;
		end
		else
		begin
			unique case (tx_reg)
				TX_IDLE:
				begin
					line_reg <= 1'b1;
					if (fifo_out_valid)
					begin
						// stop, even parity, data lsb first, start
						shift_reg    <= {1'b1, ^fifo_out_data, fifo_out_data, 1'b0};
						line_reg     <= 1'b0;
						bit_cnt_reg  <= '0;
						baud_cnt_reg <= '0;
						tx_reg       <= TX_SHIFT;
					end
				end
				TX_SHIFT:
				begin
					if (baud_cnt_reg != BIT_LAST)
						baud_cnt_reg <= baud_cnt_reg + 1'b1;
					else
					begin
						baud_cnt_reg <= '0;
						if (bit_cnt_reg == LAST_BIT)
						begin
							line_reg <= 1'b1;
							tx_reg   <= TX_IDLE;
						end
						else
						begin
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
							line_reg    <= shift_reg[bit_cnt_reg + 4'h1];
						end
					end
				end
			endcase
		end
	end

	assign turns_serial_out = line_reg;

	// ****************************************
	// hand-back to pulse mode
	// ****************************************
	// timer starts once the report's CR leaves the line
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			report_sent_reg <= 1'b0;
			gap_run_reg     <= 1'b0;
			gap_cnt_reg     <= '0;
			pulse_mode_reg  <= 1'b0;
		end
		else if (prod_reg == PR_IDLE && cmd_rise)
		begin
			// a new report takes the line back from pulse mode
			report_sent_reg <= 1'b1;
			gap_run_reg     <= 1'b0;
			pulse_mode_reg  <= 1'b0;
		end
		else if (report_sent_reg && prod_reg == PR_IDLE && !fifo_out_valid
			&& tx_reg == TX_IDLE)
		begin
			report_sent_reg <= 1'b0;
			gap_run_reg     <= 1'b1;
			gap_cnt_reg     <= '0;
		end
		else if (gap_run_reg)
		begin
			if (gap_cnt_reg == GAP_LAST)
			begin
				gap_run_reg    <= 1'b0;
				pulse_mode_reg <= 1'b1;
			end
			else
				gap_cnt_reg <= gap_cnt_reg + 1'b1;
		end
	end

	assign pulse_mode_active = pulse_mode_reg;
	assign report_busy       = (prod_reg != PR_IDLE) || fifo_out_valid || (tx_reg != TX_IDLE);

endmodule : atsr_reporter

// ---- atsr_reporter_asserts.sv ----
`timescale 1ns/10ps

module atsr_reporter_asserts
	import atsr_pkg::*;
#(
	parameter int unsigned GAP_CYC = GAP_CYCLES
)(
	input wire logic               sys_clk,             // system clock
	input wire logic               rst,                 // sync reset, high
	input wire atsr_step_s         rev_step,            // revolution pulses
	input wire logic               abs_encoder_fitted,  // encoder present
	input wire logic               motor_power_on,      // motor energised
	input wire logic               sensor_activate_cmd, // host command
	input wire logic [15:0]        turn_wrap_limit,     // limit setting
	input wire logic               turns_serial_out,    // serial line
	input wire logic               pulse_mode_active,   // pulse mode flag
	input wire logic [COUNT_W-1:0] turn_count,          // revolution count
	input wire logic               report_busy          // transfer in flight
);
	logic        custom;
	int unsigned idle_reg;
	logic [15:0] lim_reg;
	logic        lim_ok_reg;

	// limit as the drive uses it: taken once after restart
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			lim_reg    <= TURN_LIMIT_DEFAULT;
			lim_ok_reg <= 1'b0;
		end
		else if (!lim_ok_reg)
		begin
			lim_reg    <= turn_wrap_limit;
			lim_ok_reg <= 1'b1;
		end
	end

	// limit only bites with an encoder and a non-default value
	assign custom = abs_encoder_fitted && (lim_reg != TURN_LIMIT_DEFAULT);

	// quiet cycles since the last transfer; saturates to stay small
	always_ff @(posedge sys_clk)
	begin
		if (rst || report_busy)
			idle_reg <= 0;
		else if (idle_reg < GAP_CYC + 8)
			idle_reg <= idle_reg + 1;
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	AST_RESET_IDLE:
		assert property (disable iff (1'b0) rst |=> turns_serial_out && !pulse_mode_active
			&& turn_count == COUNT_ZERO && !report_busy) else $error("reset values wrong");
	AST_FWD_STEP:
		assert property (rev_step == 2'b10 && !(custom && turn_count == lim_reg)
			|=> turn_count == $past(turn_count) + COUNT_ONE) else $error("forward step lost");
	AST_REV_STEP:
		assert property (rev_step == 2'b01 && !(custom && turn_count == COUNT_ZERO)
			|=> turn_count == $past(turn_count) - COUNT_ONE) else $error("reverse step lost");
	AST_WRAP_FWD:
		assert property (custom && rev_step == 2'b10 && turn_count == lim_reg
			|=> turn_count == COUNT_ZERO) else $error("limit did not clear");
	AST_WRAP_REV:
		assert property (custom && rev_step == 2'b01 && turn_count == COUNT_ZERO
			|=> turn_count == lim_reg) else $error("zero did not load limit");
	AST_NO_STEP:
		assert property (rev_step.fwd == rev_step.rev |=> $stable(turn_count))
			else $error("count moved without step");
	AST_IDLE_HIGH:
		assert property (!report_busy |-> turns_serial_out) else $error("line low while idle");
	AST_POWERED_IGNORE:
		assert property (motor_power_on && $past(motor_power_on) && !report_busy
			|=> !report_busy) else $error("command taken while powered");
	AST_REPORT_START:
		assert property ($rose(sensor_activate_cmd) && !motor_power_on && !report_busy
			|-> ##[2:60] !turns_serial_out) else $error("no start bit after command");
	AST_PULSE_DROP:
		assert property ($rose(sensor_activate_cmd) && !motor_power_on && !report_busy
			|-> ##[1:2] !pulse_mode_active) else $error("pulse mode kept on command");
	AST_GAP_WAIT:
		assert property ($rose(pulse_mode_active) |-> idle_reg >= GAP_CYC - 2)
			else $error("pulse mode back too early");

	// main scenarios reached
	cover property ($rose(pulse_mode_active));
	cover property (custom && rev_step == 2'b01 && turn_count == COUNT_ZERO);
	cover property ($fell(sensor_activate_cmd) && !motor_power_on);
endmodule : atsr_reporter_asserts

bind atsr_reporter atsr_reporter_asserts #(.GAP_CYC(GAP_CYC)) u_asserts (
	.sys_clk(sys_clk), .rst(rst), .rev_step(rev_step), .abs_encoder_fitted(abs_encoder_fitted),
	.motor_power_on(motor_power_on), .sensor_activate_cmd(sensor_activate_cmd),
	.turn_wrap_limit(turn_wrap_limit), .turns_serial_out(turns_serial_out),
	.pulse_mode_active(pulse_mode_active), .turn_count(turn_count), .report_busy(report_busy));

// ---- atsr_host_model.sv ----
`timescale 1ns/10ps

module atsr_host_model
	import atsr_pkg::*;
#(
	parameter int unsigned BIT_CYC = BIT_CYCLES
)(
	input  wire logic              sys_clk,    // system clock
	input  wire logic              rst,        // sync reset, high
	input  wire logic              line_in,    // serial line from drive
	output logic                   char_valid, // one-cycle char strobe
	output logic      [CHAR_W-1:0] char_data,  // received code
	output logic                   frame_err   // start, parity or stop bad
);
	logic       busy_reg;
	int         cnt_reg;
	int         idx_reg;
	logic [9:0] frame_reg;

	// hunt start bit, sample mid-bit, lsb first, even parity
	always_ff @(posedge sys_clk)
	begin
		char_valid <= 1'b0;
		if (rst)
			busy_reg <= 1'b0;
		else if (!busy_reg)
		begin
			busy_reg <= !line_in;
			cnt_reg  <= BIT_CYC / 2;
			idx_reg  <= 0;
		end
		else if (cnt_reg != 0)
			cnt_reg <= cnt_reg - 1;
		else
		begin
			frame_reg[idx_reg] <= line_in;
			cnt_reg            <= BIT_CYC - 1;
			idx_reg            <= idx_reg + 1;
			// stop bit judged at its middle, ready for the next start
			if (idx_reg == 9)
			begin
				busy_reg   <= 1'b0;
				char_valid <= 1'b1;
				char_data  <= frame_reg[7:1];
				frame_err  <= frame_reg[0] | !line_in | (^frame_reg[8:1]);
			end
		end
	end
endmodule : atsr_host_model

// ---- atsr_reporter_tb_top.sv ----
`timescale 1ns/10ps

module atsr_reporter_tb_top
	import atsr_pkg::*;
;
	localparam int unsigned BIT = 8;
	localparam int unsigned GAP = 50;

	logic               sys_clk;
	logic               rst;
	atsr_step_s         rev_step;
	logic               motor;
	logic               cmd;
	logic [15:0]        limit;
	logic [7:0]         alarm;
	logic               sout;
	logic               pmode;
	logic [COUNT_W-1:0] cnt;
	logic               busy;
	logic               cv;
	logic [CHAR_W-1:0]  cd;
	logic               fe;
	logic [CHAR_W-1:0]  rxq[$];
	logic [15:0]        mc;
	logic               cust;
	logic               enc;
	logic [15:0]        lim_m;
	int                 n_errors;
	int                 n_checks;

	// 25 ns clock
	always #12.5 sys_clk = ~sys_clk;

	atsr_reporter #(.BIT_CYC(BIT), .GAP_CYC(GAP)) dut (.sys_clk(sys_clk), .rst(rst),
		.rev_step(rev_step), .abs_encoder_fitted(enc), .motor_power_on(motor),
		.sensor_activate_cmd(cmd), .turn_wrap_limit(limit), .alarm_code(alarm),
		.turns_serial_out(sout), .pulse_mode_active(pmode), .turn_count(cnt),
		.report_busy(busy));

	atsr_host_model #(.BIT_CYC(BIT)) host (.sys_clk(sys_clk), .rst(rst), .line_in(sout),
		.char_valid(cv), .char_data(cd), .frame_err(fe));

	// ****************************************
	// checking helpers
	// ****************************************
	task automatic chk_val(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk_val

	task automatic chk_char(input string nm, input logic [6:0] e, input logic [6:0] g);
		chk_val(nm, {9'h000, e}, {9'h000, g});
	endtask : chk_char

	task automatic chk_flag(input string nm, input logic e, input logic g);
		chk_val(nm, {15'h0000, e}, {15'h0000, g});
	endtask : chk_flag

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	// bounded wait; running out ends the run
	task automatic wait_for(input string nm, ref logic sig, input logic lvl, input int lim);
		int k;
		k = 0;
		while (sig !== lvl && k < lim)
		begin
			@(posedge sys_clk);
			k++;
		end
		chk_flag(nm, lvl, sig);
		if (sig !== lvl)
			end_of_test();
	endtask : wait_for

	always @(posedge sys_clk)
	begin
		if (cv)
		begin
			rxq.push_back(cd);
			chk_flag("frame_err", 1'b0, fe);
		end
	end

	// count model: 16-bit wrap, or 0..limit with a custom limit
	function automatic logic [15:0] nxt(input logic [15:0] m, input logic [1:0] s);
		if (s == 2'b10)
			return (cust && m == lim_m) ? 16'h0000 : m + 16'h0001;
		if (s == 2'b01)
			return (cust && m == 16'h0000) ? lim_m : m - 16'h0001;
		return m;
	endfunction : nxt

	function automatic logic [6:0] rep_char(input int i);
		logic neg;
		int   mag;
		neg = !cust && mc[15];
		mag = neg ? 65536 - int'(mc) : int'(mc);
		case (i)
			0: return ASC_P;
			1: return neg ? ASC_MINUS : ASC_PLUS;
			7: return ASC_CR;
			default: return ASC_ZERO + 7'((mag / (10 ** (6 - i))) % 10);
		endcase
	endfunction : rep_char

	function automatic logic [6:0] hexc(input logic [3:0] n);
		return (n < 4'hA) ? ASC_ZERO + 7'(n) : ASC_A + 7'(n - 4'hA);
	endfunction : hexc

	function automatic logic [6:0] alm_char(input int i);
		case (i)
			0: return ASC_A;
			1: return ASC_L;
			2: return ASC_M;
			3: return hexc(alarm[7:4]);
			4: return hexc(alarm[3:0]);
			5: return ASC_DOT;
			default: return ASC_CR;
		endcase
	endfunction : alm_char

	// ****************************************
	// stimulus tasks
	// ****************************************
	task automatic do_reset(input logic [15:0] lim, input logic c);
		@(posedge sys_clk);
		rst   <= 1'b1;
		limit <= lim;
		cust = c;
		mc = 16'h0000;
		lim_m = lim;
		cyc(20);
		#1;
		chk_flag("line", 1'b1, sout);
		chk_flag("pulse_mode", 1'b0, pmode);
		chk_val("turn_count", 16'h0000, cnt);
		@(posedge sys_clk);
		rst <= 1'b0;
		cyc(2);
	endtask : do_reset

	// steps go back to back; count checked one edge behind
	task automatic stp(input logic [1:0] s);
		@(posedge sys_clk);
		rev_step <= s;
		#1;
		chk_val("turn_count", mc, cnt);
		mc = nxt(mc, s);
	endtask : stp

	task automatic rx_expect(input bit alm);
		int k;
		for (int i = 0; i < (alm ? 7 : 8); i++)
		begin
			k = 0;
			while (rxq.size() == 0 && k < 400)
			begin
				@(posedge sys_clk);
				k++;
			end
			chk_val("rx_count", 16'h0001, 16'(rxq.size() > 0));
			if (rxq.size() == 0)
				end_of_test();
			chk_char("char", alm ? alm_char(i) : rep_char(i), rxq.pop_front());
		end
	endtask : rx_expect

	task automatic full_cycle(input string nm);
		@(posedge sys_clk);
		cmd <= 1'b1;
		cyc(2);
		#1;
		chk_flag("pulse_mode", 1'b0, pmode);
		rx_expect(1'b0);
		wait_for("pulse_mode", pmode, 1'b1, GAP + 200);
		@(posedge sys_clk);
		alarm <= 8'($urandom());
		cmd   <= 1'b0;
		rx_expect(1'b1);
		wait_for("busy", busy, 1'b0, 300);
		// powered motor: both edges must be lost
		@(posedge sys_clk);
		motor <= 1'b1;
		@(posedge sys_clk);
		cmd <= 1'b1;
		cyc(3);
		cmd <= 1'b0;
		cyc(60);
		#1;
		chk_val("rx_count", 16'h0000, 16'(rxq.size()));
		chk_flag("busy", 1'b0, busy);
		@(posedge sys_clk);
		motor <= 1'b0;
		cyc(2);
		$display("test %s done", nm);
	endtask : full_cycle

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		sys_clk = 1'b0;
		rst = 1'b1;
		rev_step = 2'b00;
		motor = 1'b0;
		cmd = 1'b0;
		limit = TURN_LIMIT_DEFAULT;
		alarm = 8'h00;
		enc = 1'b1;
		n_errors = 0;
		n_checks = 0;
		void'($urandom(32'h8424));
		// reset values, then a zero report
		do_reset(TURN_LIMIT_DEFAULT, 1'b0);
		full_cycle("zero");
		repeat (400) stp(2'($urandom()));
		stp(2'b00);
		full_cycle("random");
		// wrap +32767 to -32768 and back, report the extreme
		while (mc != 16'h7FFF) stp(2'b10);
		stp(2'b10);
		stp(2'b01);
		stp(2'b10);
		stp(2'b00);
		full_cycle("wrap");
		// limit of 300 turns minus one
		do_reset(16'h012B, 1'b1);
		stp(2'b01);
		stp(2'b10);
		stp(2'b10);
		stp(2'b01);
		stp(2'b01);
		stp(2'b00);
		// a new limit is ignored until the next restart
		@(posedge sys_clk);
		limit <= 16'h0005;
		repeat (200) stp(2'($urandom()));
		stp(2'b00);
		full_cycle("limit");
		// no encoder: limit ignored, falling command sends nothing
		enc <= 1'b0;
		do_reset(16'h012B, 1'b0);
		stp(2'b01);
		stp(2'b01);
		stp(2'b10);
		stp(2'b00);
		@(posedge sys_clk);
		cmd <= 1'b1;
		rx_expect(1'b0);
		@(posedge sys_clk);
		cmd <= 1'b0;
		cyc(120);
		#1;
		chk_val("rx_count", 16'h0000, 16'(rxq.size()));
		chk_flag("busy", 1'b0, busy);
		$display("test %s done", "no_encoder");
		end_of_test();
	end
endmodule : atsr_reporter_tb_top
